/* File: hw/pss_pkg.sv */
// constants shared by the supply sequencer design
package pss_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int REG_CYCLE_HZ = 40000;
	// one regulator cycle in clock cycles
	localparam int REG_CYCLE_CYC = CLK_HZ / REG_CYCLE_HZ;
	localparam int RETRY_DELAY_S = 2;
	localparam int RETRY_DELAY_CYC = RETRY_DELAY_S * CLK_HZ;
	localparam int RETRY_MAX = 5;
	localparam int SAVE_DELAY_US = 100;
	localparam int SAVE_DELAY_CYC = SAVE_DELAY_US * (CLK_HZ / 1000000);
	localparam int LIMIT_MAX_CYCLES = 64;
	localparam int STEP_DELAY_US = 10;
	localparam int STEP_DELAY_CYC = STEP_DELAY_US * (CLK_HZ / 1000000);
	localparam int MARGIN_W = 8;
	localparam logic [7:0] MARGIN_RST = 8'h00;

	typedef enum logic [6:0]
	{
		PSS_OFF = 7'h01,
		PSS_RELAY = 7'h02,
		PSS_CHOP = 7'h04,
		PSS_RUN = 7'h08,
		PSS_SAVE = 7'h10,
		PSS_RETRY = 7'h20,
		PSS_BATT = 7'h40
	} pss_state_t;
endpackage : pss_pkg

/* File: hw/pss_sequencer.sv */
// power supply sequencer, fault detection, retry and battery switchover
`timescale 1ns/1ps
module pss_sequencer
	import pss_pkg::*;
#(
	parameter int RETRY_CYC = RETRY_DELAY_CYC,
	parameter int RETRIES = RETRY_MAX,
	parameter int SAVE_CYC = SAVE_DELAY_CYC,
	parameter int PERIOD_CYC = REG_CYCLE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// sequencing inputs
	input wire logic switch_on_in_i,
	input wire logic ramp_running_i,
	input wire logic bulk_voltage_sense_i,
	// fault inputs
	input wire logic rail12_overload_i,
	input wire logic short_circuit_detect_i,
	input wire logic primary_limit_i,
	input wire logic overvolt_i,
	input wire logic memory_disaster_in_i,
	input wire logic undervolt_i,
	input wire logic mem_voltage_good_i,
	// margining pattern from the CPU
	input wire logic [MARGIN_W-1:0] margin_data_i,
	input wire logic margin_strobe_i,
	// sequencing outputs
	output logic relay_close_o,
	output logic chopper_start_o,
	output logic power_on_enable_o,
	output logic comp_enable_o,
	output logic charger_enable_o,
	output logic battery_on_o,
	// status outputs
	output logic power_good_o,
	output logic power_on_led_o,
	output logic power_fail_o,
	output logic overcurrent_led_o,
	output logic overvolt_led_o,
	output logic mem_disaster_led_o,
	output logic latched_off_o,
	// margin outputs
	output logic margin_5v_up_o,
	output logic margin_5v_down_o,
	output logic margin_12v_up_o,
	output logic margin_12v_down_o,
	output logic margin_neg5v_up_o,
	output logic margin_neg5v_down_o,
	output logic undervolt_threshold_lower_o,
	output logic forced_overcurrent_o
);
	// refuse parameters that the counters cannot serve
	if (RETRY_CYC < 1 || SAVE_CYC < 1 || PERIOD_CYC < 2 || RETRIES < 0 || RETRIES > 15)
	begin : g_param_check
		$error("pss_sequencer: unsupported parameter values");
	end

	localparam int TW = 32;

	logic [10:0] raw_in;
	logic [10:0] syn;
	assign raw_in = {switch_on_in_i, ramp_running_i, bulk_voltage_sense_i, rail12_overload_i,
		short_circuit_detect_i, primary_limit_i, overvolt_i, memory_disaster_in_i, undervolt_i,
		mem_voltage_good_i, margin_strobe_i};

	pss_sync #(.W(11)) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(raw_in),
		.q_o(syn)
	);

	logic sw_on, ramp_ok, bulk_ok, ovl12, short_circuit_detect, plim, ovv, memory_disaster_in, uv, memok, strobe;
	assign {sw_on, ramp_ok, bulk_ok, ovl12, short_circuit_detect, plim, ovv, memory_disaster_in, uv, memok, strobe} = syn;

	// margin data is sampled only on a synchronised strobe, so it is settled by then
	logic [MARGIN_W-1:0] margin_r, margin_nxt;
	logic strobe_d_r, strobe_d_nxt;

	pss_state_t state_r, state_nxt;
	logic [TW-1:0] timer_r, timer_nxt;
	logic [3:0] retry_r, retry_nxt;
	logic [TW-1:0] period_r, period_nxt;
	logic limit_cut_r, limit_cut_nxt;
	logic [7:0] limit_cnt_r, limit_cnt_nxt;
	logic limit_force_r, limit_force_nxt;
	logic oc_led_r, oc_led_nxt, ov_led_r, ov_led_nxt, md_led_r, md_led_nxt;
	logic latched_r, latched_nxt;
	logic pfail_r, pfail_nxt, pgood_r, pgood_nxt;
	logic relay_r, relay_nxt, chop_r, chop_nxt, pon_r, pon_nxt, comp_r, comp_nxt, bat_r, bat_nxt;
	logic forced_oc;
	logic oc_fault;
	logic pwr_fault;
	logic start_ok;

	assign forced_oc = margin_r[7] | limit_force_r;
	assign oc_fault = ovl12 | short_circuit_detect | forced_oc;
	assign pwr_fault = oc_fault | ovv | memory_disaster_in;
	assign start_ok = sw_on & ramp_ok & bulk_ok;

	always_comb
	begin
		margin_nxt = margin_r;
		strobe_d_nxt = strobe;
		if (strobe && !strobe_d_r)
			margin_nxt = margin_data_i;
		if (!sw_on)
			margin_nxt = MARGIN_RST;
	end

	always_comb
	begin
		period_nxt = (period_r == TW'(PERIOD_CYC - 1)) ? '0 : period_r + TW'(1);
		limit_cut_nxt = limit_cut_r;
		limit_cnt_nxt = limit_cnt_r;
		limit_force_nxt = limit_force_r;
		if (period_r == TW'(PERIOD_CYC - 1))
		begin
			if (limit_cut_r)
				limit_cnt_nxt = (limit_cnt_r == 8'hFF) ? limit_cnt_r : limit_cnt_r + 8'h01;
			else
				limit_cnt_nxt = 8'h00;
			limit_cut_nxt = 1'b0;
		end
		if (plim && state_r == PSS_RUN)
			limit_cut_nxt = 1'b1;
		if (limit_cnt_r >= 8'(LIMIT_MAX_CYCLES))
			limit_force_nxt = 1'b1;
		if (state_r != PSS_RUN)
		begin
			limit_cnt_nxt = 8'h00;
			limit_force_nxt = 1'b0;
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		timer_nxt = (timer_r != '0) ? timer_r - TW'(1) : timer_r;
		retry_nxt = retry_r;
		oc_led_nxt = oc_led_r;
		ov_led_nxt = ov_led_r;
		md_led_nxt = md_led_r;
		latched_nxt = latched_r;
		case (state_r)
			PSS_OFF:
			begin
				if (!sw_on)
				begin
					retry_nxt = 4'h0;
					latched_nxt = 1'b0;
				end
				if (start_ok && !latched_r)
				begin
					oc_led_nxt = 1'b0;
					ov_led_nxt = 1'b0;
					md_led_nxt = 1'b0;
					state_nxt = PSS_RELAY;
					timer_nxt = TW'(STEP_DELAY_CYC);
				end
			end
			PSS_RELAY:
			begin
				if (timer_r == '0)
				begin
					state_nxt = PSS_CHOP;
					timer_nxt = TW'(STEP_DELAY_CYC);
				end
			end
			PSS_CHOP:
			begin
				if (timer_r == '0)
					state_nxt = PSS_RUN;
			end
			PSS_RUN:
			begin
				state_nxt = PSS_RUN;
			end
			PSS_SAVE:
			begin
				if (timer_r == '0)
					state_nxt = PSS_OFF;
			end
			PSS_RETRY:
			begin
				if (!sw_on)
				begin
					state_nxt = PSS_OFF;
				end
				else if (timer_r == '0)
				begin
					retry_nxt = retry_r + 4'h1;
					state_nxt = PSS_OFF;
				end
			end
			PSS_BATT:
			begin
				if (!memok || !sw_on)
					state_nxt = PSS_OFF;
				else if (start_ok && !memory_disaster_in && !ovv && !uv)
					state_nxt = PSS_RELAY;
			end
			default:
			begin
				state_nxt = PSS_OFF;
			end
		endcase
		if (state_r == PSS_RELAY || state_r == PSS_CHOP || state_r == PSS_RUN)
		begin
			if (oc_fault)
			begin
				oc_led_nxt = 1'b1;
				if (retry_r >= 4'(RETRIES))
				begin
					latched_nxt = 1'b1;
					state_nxt = PSS_OFF;
				end
				else
				begin
					state_nxt = PSS_RETRY;
					timer_nxt = TW'(RETRY_CYC);
				end
			end
			else if (ovv)
			begin
				// overvoltage
				// latch off, or the start check would restart into the same fault
				ov_led_nxt = 1'b1;
				latched_nxt = 1'b1;
				state_nxt = PSS_OFF;
			end
			else if (memory_disaster_in)
			begin
				md_led_nxt = 1'b1;
				latched_nxt = 1'b1;
				state_nxt = PSS_OFF;
			end
			else if (!sw_on)
			begin
				state_nxt = PSS_SAVE;
				timer_nxt = TW'(SAVE_CYC);
			end
			else if (!ramp_ok || !bulk_ok || uv)
			begin
				state_nxt = memok ? PSS_BATT : PSS_OFF;
			end
		end
	end

	// outputs from next state
	always_comb
	begin
		relay_nxt = (state_nxt == PSS_RELAY) || (state_nxt == PSS_CHOP) || (state_nxt == PSS_RUN)
			|| (state_nxt == PSS_SAVE);
		chop_nxt = (state_nxt == PSS_CHOP) || (state_nxt == PSS_RUN);
		pon_nxt = (state_nxt == PSS_RUN) && !limit_cut_nxt;
		comp_nxt = (state_nxt == PSS_RUN);
		bat_nxt = (state_nxt == PSS_BATT);
		pgood_nxt = (state_nxt == PSS_RUN) && !uv;
		pfail_nxt = !pgood_nxt || !sw_on || !bulk_ok;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			margin_r <= MARGIN_RST;
			strobe_d_r <= 1'b0;
			state_r <= PSS_OFF;
			timer_r <= '0;
			retry_r <= 4'h0;
			period_r <= '0;
			limit_cut_r <= 1'b0;
			limit_cnt_r <= 8'h00;
			limit_force_r <= 1'b0;
			oc_led_r <= 1'b0;
			ov_led_r <= 1'b0;
			md_led_r <= 1'b0;
			latched_r <= 1'b0;
			relay_r <= 1'b0;
			chop_r <= 1'b0;
			pon_r <= 1'b0;
			comp_r <= 1'b0;
			bat_r <= 1'b0;
			pgood_r <= 1'b0;
			pfail_r <= 1'b1;
		end
		else
		begin
			margin_r <= margin_nxt;
			strobe_d_r <= strobe_d_nxt;
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			retry_r <= retry_nxt;
			period_r <= period_nxt;
			limit_cut_r <= limit_cut_nxt;
			limit_cnt_r <= limit_cnt_nxt;
			limit_force_r <= limit_force_nxt;
			oc_led_r <= oc_led_nxt;
			ov_led_r <= ov_led_nxt;
			md_led_r <= md_led_nxt;
			latched_r <= latched_nxt;
			relay_r <= relay_nxt;
			chop_r <= chop_nxt;
			pon_r <= pon_nxt;
			comp_r <= comp_nxt;
			bat_r <= bat_nxt;
			pgood_r <= pgood_nxt;
			pfail_r <= pfail_nxt;
		end
	end

	assign relay_close_o = relay_r;
	assign chopper_start_o = chop_r;
	assign power_on_enable_o = pon_r;
	assign comp_enable_o = comp_r;
	assign charger_enable_o = relay_r;
	assign battery_on_o = bat_r;
	assign power_good_o = pgood_r;
	assign power_on_led_o = pgood_r;
	assign power_fail_o = pfail_r;
	assign overcurrent_led_o = oc_led_r;
	assign overvolt_led_o = ov_led_r;
	assign mem_disaster_led_o = md_led_r;
	assign latched_off_o = latched_r;
	assign {forced_overcurrent_o, undervolt_threshold_lower_o, margin_neg5v_down_o, margin_neg5v_up_o,
		margin_12v_down_o, margin_12v_up_o, margin_5v_down_o, margin_5v_up_o} = {forced_oc, margin_r[6:0]};
endmodule : pss_sequencer

/* File: hw/pss_sync.sv */
// two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module pss_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	always_comb
	begin
		meta_nxt = d_i;
		q_nxt = meta_r;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			q_o <= q_nxt;
		end
	end
endmodule : pss_sync

/* File: verification/pss_sequencer_monitor.sv */
// port assertions for the supply sequencer
`timescale 1ns/1ps
module pss_sequencer_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// watched inputs
	input wire logic switch_on_in_i,
	input wire logic ramp_running_i,
	input wire logic bulk_voltage_sense_i,
	// watched outputs
	input wire logic relay_close_o,
	input wire logic chopper_start_o,
	input wire logic power_on_enable_o,
	input wire logic comp_enable_o,
	input wire logic charger_enable_o,
	input wire logic battery_on_o,
	input wire logic overcurrent_led_o,
	input wire logic mem_disaster_led_o,
	input wire logic latched_off_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// inputs pass a two stage synchroniser, so look two samples back
	sequence s_ready;
		$past(switch_on_in_i, 2) && $past(ramp_running_i, 2) && $past(bulk_voltage_sense_i, 2);
	endsequence
	sequence s_off;
		!switch_on_in_i [*5];
	endsequence
	AST_START: assert property ($rose(relay_close_o) |-> s_ready)
		else $error("relay closed without start conditions");
	AST_CHOP_ORDER: assert property ($rose(chopper_start_o) |-> relay_close_o)
		else $error("chopper started before relay");
	AST_PON_ORDER: assert property ($rose(power_on_enable_o) |-> chopper_start_o && relay_close_o)
		else $error("power on before chopper");
	AST_CHARGER: assert property (charger_enable_o == relay_close_o)
		else $error("charger enable differs from relay");
	AST_OC_SHUT: assert property ($rose(overcurrent_led_o) |-> ##[0:2] (!power_on_enable_o && !comp_enable_o))
		else $error("overcurrent did not drop power on");
	AST_BATT_PON: assert property (battery_on_o |-> !power_on_enable_o)
		else $error("battery on with power on");
	AST_MEMORY_DISASTER_IN_BATT: assert property (mem_disaster_led_o |-> !battery_on_o)
		else $error("battery on after memory disaster");
	AST_SW_OFF: assert property (s_off |-> !power_on_enable_o && !chopper_start_o && !battery_on_o)
		else $error("supply alive with switch off");
	AST_LATCH: assert property (latched_off_o |-> !relay_close_o)
		else $error("relay closed while latched off");
endmodule : pss_sequencer_monitor

bind pss_sequencer pss_sequencer_monitor i_mon (.*);

/* File: verification/pss_sequencer_tb.sv */
// self-checking bench for the supply sequencer
`timescale 1ns/1ps
module pss_sequencer_tb;
	import pss_pkg::*;
	localparam int RETRY_T = 50;
	localparam int SAVE_T = 10;
	localparam int PER_T = 8;
	localparam int R = 0, C = 1, P = 2, B = 3, G = 4, F = 5, OC = 6, OV = 7, MD = 8, FO = 9;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic switch_on_in_i = 1'b0, rail12_overload_i = 1'b0, short_circuit_detect_i = 1'b0;
	logic primary_limit_i = 1'b0, overvolt_i = 1'b0, memory_disaster_in_i = 1'b0, undervolt_i = 1'b0;
	logic margin_strobe_i = 1'b0, mains = 1'b0, batt = 1'b1;
	logic [MARGIN_W-1:0] margin_data_i = MARGIN_RST;
	logic ramp_running_i, bulk_voltage_sense_i, mem_voltage_good_i;
	logic relay_close_o, chopper_start_o, power_on_enable_o, comp_enable_o, charger_enable_o, battery_on_o;
	logic power_good_o, power_on_led_o, power_fail_o, overcurrent_led_o, overvolt_led_o;
	logic mem_disaster_led_o, latched_off_o, undervolt_threshold_lower_o, forced_overcurrent_o;
	logic margin_5v_up_o, margin_5v_down_o, margin_12v_up_o, margin_12v_down_o, margin_neg5v_up_o, margin_neg5v_down_o;
	logic [9:0] obs;
	logic [7:0] mg;
	int error_cnt = 0;
	int checks = 0;
	assign obs = {forced_overcurrent_o, mem_disaster_led_o, overvolt_led_o, overcurrent_led_o, power_fail_o,
		power_good_o, battery_on_o, power_on_enable_o, chopper_start_o, relay_close_o};
	assign mg = {forced_overcurrent_o, undervolt_threshold_lower_o, margin_neg5v_down_o, margin_neg5v_up_o,
		margin_12v_down_o, margin_12v_up_o, margin_5v_down_o, margin_5v_up_o};
	pss_sequencer #(.RETRY_CYC(RETRY_T), .SAVE_CYC(SAVE_T), .PERIOD_CYC(PER_T)) i_dut (.*);
	pss_supply_model i_sup (.clk_i(clk_i), .mains_ok_i(mains), .batt_ok_i(batt),
		.ramp_running_o(ramp_running_i), .bulk_voltage_sense_o(bulk_voltage_sense_i),
		.mem_voltage_good_o(mem_voltage_good_i));
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end
	task results;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task chk(input string n, input logic e, input logic g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s exp %b got %b", n, e, g);
		end
	endtask : chk
	task wt(input int k, input logic v, input int n);
		for (int i = 0; i < n && obs[k] !== v; i++)
			@(negedge clk_i);
		chk($sformatf("wait%0d", k), v, obs[k]);
		if (obs[k] !== v)
			results();
	endtask : wt
	task off_on;
		{rail12_overload_i, short_circuit_detect_i, overvolt_i, memory_disaster_in_i, undervolt_i} = 5'h00;
		switch_on_in_i = 1'b0;
		wt(R, 1'b0, SAVE_T + 20);
		repeat (6) @(negedge clk_i);
		mains = 1'b1;
		switch_on_in_i = 1'b1;
		wt(P, 1'b1, 1000);
	endtask : off_on
	task t_up;
		switch_on_in_i = 1'b1;
		repeat (20) @(negedge clk_i);
		chk("relay_no_bulk", 1'b0, relay_close_o);
		mains = 1'b1;
		wt(R, 1'b1, 20);
		chk("chop_early", 1'b0, chopper_start_o);
		wt(C, 1'b1, 400);
		chk("pon_early", 1'b0, power_on_enable_o);
		wt(P, 1'b1, 400);
		chk("batt_run", 1'b0, battery_on_o);
		chk("good_run", 1'b1, power_good_o & power_on_led_o & comp_enable_o);
		chk("charger", 1'b1, charger_enable_o);
		$display("test up done");
	endtask : t_up
	task t_margin;
		for (int b = 0; b < 8; b++)
		begin
			margin_data_i = 8'h01 << b;
			margin_strobe_i = 1'b1;
			repeat (2) @(negedge clk_i);
			margin_strobe_i = 1'b0;
			repeat (4) @(negedge clk_i);
			chk("margin", 1'b1, mg === (8'h01 << b));
		end
		wt(OC, 1'b1, 20);
		off_on();
		$display("test margin done");
	endtask : t_margin
	task t_limit;
		primary_limit_i = 1'b1;
		@(negedge clk_i);
		primary_limit_i = 1'b0;
		wt(P, 1'b0, 6);
		wt(P, 1'b1, PER_T + 6);
		primary_limit_i = 1'b1;
		wt(FO, 1'b1, 64 * PER_T + 60);
		primary_limit_i = 1'b0;
		off_on();
		$display("test limit done");
	endtask : t_limit
	task t_fault;
		for (int k = 0; k < 4; k++)
		begin
			{rail12_overload_i, short_circuit_detect_i, overvolt_i, memory_disaster_in_i} = 4'h8 >> k;
			wt(k < 2 ? OC : OV + k - 2, 1'b1, 20);
			chk("fault_pon", 1'b0, power_on_enable_o | comp_enable_o);
			chk("fault_latch", k >= 2, latched_off_o);
			repeat (10) @(negedge clk_i);
			chk("fault_batt", 1'b0, battery_on_o);
			off_on();
		end
		$display("test fault done");
	endtask : t_fault
	task t_latch;
		int n;
		logic p;
		n = 0;
		p = relay_close_o;
		rail12_overload_i = 1'b1;
		for (int i = 0; i < 20000 && latched_off_o !== 1'b1; i++)
		begin
			@(negedge clk_i);
			if (relay_close_o === 1'b1 && p !== 1'b1)
				n++;
			p = relay_close_o;
		end
		chk("retries", 1'b1, n == RETRY_MAX);
		chk("latched_relay", 1'b0, relay_close_o);
		off_on();
		chk("latch_clear", 1'b0, latched_off_o | overcurrent_led_o);
		$display("test latch done");
	endtask : t_latch
	task t_batt;
		undervolt_i = 1'b1;
		wt(G, 1'b0, 10);
		chk("on_led", 1'b0, power_on_led_o);
		wt(F, 1'b1, 10);
		wt(B, 1'b1, 20);
		batt = 1'b0;
		wt(B, 1'b0, 10);
		chk("batt_relay", 1'b0, relay_close_o);
		batt = 1'b1;
		off_on();
		mains = 1'b0;
		wt(F, 1'b1, 10);
		wt(B, 1'b1, 20);
		switch_on_in_i = 1'b0;
		wt(B, 1'b0, 10);
		off_on();
		$display("test battery done");
	endtask : t_batt
	task t_swoff;
		switch_on_in_i = 1'b0;
		wt(P, 1'b0, 6);
		wt(F, 1'b1, 6);
		chk("chop_off", 1'b0, chopper_start_o);
		repeat (SAVE_T / 2) @(negedge clk_i);
		chk("relay_save", 1'b1, relay_close_o);
		wt(R, 1'b0, SAVE_T + 6);
		$display("test switch off done");
	endtask : t_swoff
	initial
	begin
		repeat (6) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_up();
		t_margin();
		t_limit();
		t_fault();
		t_latch();
		t_batt();
		t_swoff();
		results();
	end
endmodule : pss_sequencer_tb

/* File: verification/pss_supply_model.sv */
// behavioural model of the ramp clock, bulk supply and battery sources
`timescale 1ns/1ps
module pss_supply_model (
	// clock
	input wire logic clk_i,
	// scenario controls
	input wire logic mains_ok_i,
	input wire logic batt_ok_i,
	// sense lines towards the sequencer
	output logic ramp_running_o = 1'b0,
	output logic bulk_voltage_sense_o = 1'b0,
	output logic mem_voltage_good_o = 1'b0
);
	// ramp and bulk sense follow the mains
	// memory rail good while the battery holds
	always_ff @(posedge clk_i)
	begin
		ramp_running_o <= mains_ok_i;
		bulk_voltage_sense_o <= mains_ok_i;
		mem_voltage_good_o <= batt_ok_i;
	end
endmodule : pss_supply_model
